// ### design/itx_master_tx.sv
// Two-wire master transmit controller: start, bytes with acknowledge, stop
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Buffer write sets full flag, starts generator
// - Drive bit after SCL falls, low one period
// - SCL high one period, SDA held stable
// - After eighth bit clear full, release SDA
// - Ninth clock captures acknowledge into status
// - After data byte set event, suspend generator
// - Address is seven bits plus direction bit
// - After address byte: event, full clear, SDA floats
// - Write while shifting sets collision, discarded
// - Start request; event flag when start done
// - Hold required start time before next operation
// - Stop or restart raises event when complete
// - Byte, acknowledge, event repeat for every byte
module itx_master_tx (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  // Software side
  input  wire logic [itx_pkg::BYTE_W-1:0]    buf_wdata_i,
  input  wire logic                          buf_write_i,
  input  wire logic                          start_req_i,
  input  wire logic                          restart_req_i,
  input  wire logic                          stop_req_i,
  input  wire logic                          event_clr_i,
  input  wire logic                          write_collision_flag_clr_i,
  input  wire logic [itx_pkg::RELOAD_W-1:0]  baud_reload_i,
  // Status
  output logic                               buffer_full_flag_o,
  output logic                               serial_event_flag_o,
  output logic                               acknowledge_status_bit_o,
  output logic                               write_collision_flag_o,
  output logic                               busy_o,
  // Two-wire pins; enable high pulls the line low
  input  wire logic                          scl_i,
  output logic                               scl_o,
  output logic                               scl_oe_o,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  itx_pkg::itx_state_t              state_reg;      // Controller state
  logic [itx_pkg::BYTE_W-1:0]       tx_buf_reg;     // Transmit buffer
  logic [itx_pkg::BYTE_W-1:0]       shift_reg;      // Outgoing bits, MSB first
  logic [itx_pkg::BITCNT_W-1:0]     bit_reg;        // Clock index in byte
  logic [1:0]                       phase_reg;      // Sub-step of start/stop
  logic                             full_reg;       // Buffer full flag
  logic                             event_reg;      // Serial event flag
  logic                             ack_reg;        // Acknowledge status
  logic                             write_collision_flag_reg;       // Write collision flag
  logic                             scl_low_reg;    // Pull SCL low
  logic                             sda_low_reg;    // Pull SDA low
  logic [2:0]                       sda_sync_reg;   // SDA synchroniser
  logic                             sda_last_reg;   // Last agreed SDA level
  logic                             wr_ok;          // Buffer write accepted
  logic                             wr_coll;        // Buffer write refused
  logic                             shifting;       // Byte on the wire
  logic                             roll;           // Baud rollover
  logic                             ev_set;         // Event this cycle
  itx_baud_if baud ();

  // ----------------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------------
  itx_baud_gen u_baud (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .baud   (baud.gen)
  );

  // Generator runs in every active state, stopped while suspended
  assign baud.run    = (state_reg != itx_pkg::ITX_IDLE) && (state_reg != itx_pkg::ITX_WAIT);
  assign baud.load   = wr_ok;
  assign baud.reload = (baud_reload_i < itx_pkg::RELOAD_MIN) ? itx_pkg::RELOAD_MIN
                                                             : baud_reload_i;
  assign roll        = baud.roll;

  // ----------------------------------------------------------------------
  // Input synchroniser for SDA
  // ----------------------------------------------------------------------
  // Three stages; only the agreeing later two are looked at
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sda_sync_reg <= itx_pkg::SYNC_RST;
    end else begin
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
    end
  end

  // Level changes once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sda_last_reg <= 1'b1;
    end else if (sda_sync_reg[1] == sda_sync_reg[2]) begin
      sda_last_reg <= sda_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------------
  // Buffer write decode
  // ----------------------------------------------------------------------
  // A byte is on the wire from the buffer write until the ninth clock ends
  assign shifting = (state_reg == itx_pkg::ITX_LOW) || (state_reg == itx_pkg::ITX_HIGH);
  // Writes taken only while suspended; a same-cycle stop or restart wins
  assign wr_ok    = buf_write_i && (state_reg == itx_pkg::ITX_WAIT) && !stop_req_i && !restart_req_i;
  assign wr_coll  = buf_write_i && shifting;
  // Scl_i unused in this transmit-only path: no clock stretching support
  assign ev_set   = ((state_reg == itx_pkg::ITX_HIGH) && roll && (bit_reg == itx_pkg::ACK_BIT))
                 || ((state_reg == itx_pkg::ITX_START_HOLD) && roll && (phase_reg == '0))
                 || ((state_reg == itx_pkg::ITX_STOP) && roll && (phase_reg == 2'h2));

  // ----------------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------------
  // Colliding write leaves contents untouched
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_buf_reg <= itx_pkg::BUF_RST;
    end else if (wr_ok) begin
      tx_buf_reg <= buf_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Buffer full flag
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      full_reg <= 1'b0;
    end else if (wr_ok) begin
      full_reg <= 1'b1;
    end else if (state_reg == itx_pkg::ITX_HIGH && roll && bit_reg == itx_pkg::DATA_BITS - 1'b1) begin
      full_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Event and collision flags; hardware set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      event_reg <= 1'b0;
    end else if (ev_set) begin
      event_reg <= 1'b1;
    end else if (event_clr_i) begin
      event_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      write_collision_flag_reg <= 1'b0;
    end else if (wr_coll) begin
      write_collision_flag_reg <= 1'b1;
    end else if (write_collision_flag_clr_i) begin
      write_collision_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Acknowledge capture
  // ----------------------------------------------------------------------
  // Sampled at the end of the ninth high phase; low means acknowledged
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ack_reg <= 1'b0;
    end else if (state_reg == itx_pkg::ITX_HIGH && roll && bit_reg == itx_pkg::ACK_BIT) begin
      ack_reg <= sda_last_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------------
  // Each step except IDLE and WAIT advances on one rollover, i.e. one baud period
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg   <= itx_pkg::ITX_IDLE;
      shift_reg   <= itx_pkg::BUF_RST;
      bit_reg     <= '0;
      phase_reg   <= itx_pkg::HALF_RST;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        itx_pkg::ITX_IDLE: begin
          if (start_req_i) begin
            state_reg   <= itx_pkg::ITX_START;
            phase_reg   <= 2'h1;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
          end
        end
        itx_pkg::ITX_START: begin
          // Phase 0: SCL low, SDA released (restart only); phase 1: SCL high
          if (roll) begin
            if (phase_reg == '0) begin
              scl_low_reg <= 1'b0;
              phase_reg   <= 2'h1;
            end else begin
              sda_low_reg <= 1'b1;
              state_reg   <= itx_pkg::ITX_START_HOLD;
              phase_reg   <= itx_pkg::START_HALVES;
            end
          end
        end
        itx_pkg::ITX_START_HOLD: begin
          // SDA low with SCL high for the start time, then pull SCL low
          if (roll) begin
            if (phase_reg == '0) begin
              scl_low_reg <= 1'b1;
              state_reg   <= itx_pkg::ITX_WAIT;
            end else begin
              phase_reg <= phase_reg - 1'b1;
            end
          end
        end
        itx_pkg::ITX_WAIT: begin
          // Suspended with SCL low; SDA as the last step left it
          if (stop_req_i) begin
            state_reg   <= itx_pkg::ITX_STOP;
            phase_reg   <= '0;
            sda_low_reg <= 1'b1;
          end else if (restart_req_i) begin
            state_reg   <= itx_pkg::ITX_START;
            phase_reg   <= '0;
            sda_low_reg <= 1'b0;
          end else if (wr_ok) begin
            // First bit goes out with SCL already low
            shift_reg   <= {buf_wdata_i[itx_pkg::BYTE_W-2:0], 1'b0};
            sda_low_reg <= ~buf_wdata_i[itx_pkg::BYTE_W-1];
            bit_reg     <= '0;
            state_reg   <= itx_pkg::ITX_LOW;
          end
        end
        itx_pkg::ITX_LOW: begin
          // SCL low for one baud period, then release
          if (roll) begin
            scl_low_reg <= 1'b0;
            state_reg   <= itx_pkg::ITX_HIGH;
          end
        end
        itx_pkg::ITX_HIGH: begin
          // SCL high one period; SDA untouched until SCL is low again
          if (roll) begin
            scl_low_reg <= 1'b1;
            if (bit_reg == itx_pkg::ACK_BIT) begin
              state_reg <= itx_pkg::ITX_WAIT;
            end else begin
              state_reg <= itx_pkg::ITX_LOW;
              bit_reg   <= bit_reg + 1'b1;
              if (bit_reg == itx_pkg::DATA_BITS - 1'b1) begin
                sda_low_reg <= 1'b0;
              end else begin
                sda_low_reg <= ~shift_reg[itx_pkg::BYTE_W-1];
                shift_reg   <= {shift_reg[itx_pkg::BYTE_W-2:0], 1'b0};
              end
            end
          end
        end
        itx_pkg::ITX_STOP: begin
          // Phase 0: SDA low; 1: SCL high; 2: SDA released high
          if (roll) begin
            if (phase_reg == '0) begin
              scl_low_reg <= 1'b0;
              phase_reg   <= 2'h1;
            end else if (phase_reg == 2'h1) begin
              sda_low_reg <= 1'b0;
              phase_reg   <= 2'h2;
            end else begin
              state_reg   <= itx_pkg::ITX_IDLE;
            end
          end
        end
        default: begin
          state_reg <= itx_pkg::ITX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs straight from flip-flops; scl_o and sda_o tied low
  // ----------------------------------------------------------------------
  assign buffer_full_flag_o       = full_reg;
  assign serial_event_flag_o      = event_reg;
  assign acknowledge_status_bit_o = ack_reg;
  assign write_collision_flag_o   = write_collision_flag_reg;
  assign scl_o                    = 1'b0;
  assign scl_oe_o                 = scl_low_reg;
  assign sda_o                    = 1'b0;
  assign sda_oe_o                 = sda_low_reg;
  // Busy while not idle; registered state compare kept as a flop
  logic busy_reg;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg != itx_pkg::ITX_IDLE);
    end
  end
  assign busy_o = busy_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_WRITE_SETS_FULL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_ok |=> full_reg && state_reg == itx_pkg::ITX_LOW) else $error("write did not start byte");
  AST_SDA_ONLY_SCL_LOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_reg == itx_pkg::ITX_HIGH && $past(state_reg) == itx_pkg::ITX_HIGH) |-> $stable(sda_low_reg))
    else $error("SDA moved while SCL high");
  AST_SCL_RELEASE_ON_ROLL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_reg == itx_pkg::ITX_LOW && roll) |=> !scl_low_reg) else $error("SCL not released");
  AST_ACK_RELEASE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_reg == itx_pkg::ITX_LOW && bit_reg == itx_pkg::ACK_BIT) |-> !sda_low_reg && !full_reg)
    else $error("SDA held in ack slot");
  AST_ACK_CAPTURE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_reg == itx_pkg::ITX_HIGH && roll && bit_reg == itx_pkg::ACK_BIT) |=> ack_reg == $past(sda_last_reg))
    else $error("acknowledge not captured");
  AST_EVENT_AFTER_NINTH: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_reg == itx_pkg::ITX_HIGH && roll && bit_reg == itx_pkg::ACK_BIT)
      |=> event_reg && state_reg == itx_pkg::ITX_WAIT && scl_low_reg) else $error("no event after byte");
  AST_WAIT_STOPS_BAUD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_reg == itx_pkg::ITX_WAIT |-> !baud.run) else $error("generator runs while suspended");
  AST_COLLISION: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_coll |=> write_collision_flag_reg && $stable(tx_buf_reg)) else $error("collision not flagged");
  AST_START_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(sda_low_reg) && !scl_low_reg |=> (!scl_low_reg)[*2]) else $error("start time too short");
endmodule
`default_nettype wire

// ### design/itx_pkg.sv
// Package of constants and types for the two-wire master transmit block
package itx_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned BYTE_W   = 8;        // Shifted byte width
  localparam int unsigned RELOAD_W = 8;        // Baud reload width
  localparam int unsigned BITCNT_W = 4;        // Bit counter width

  // ----------------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0]          DATA_BITS    = 4'h8;   // Bits before acknowledge
  localparam logic [3:0]          ACK_BIT      = 4'h8;   // Index of the ninth clock
  localparam logic [RELOAD_W-1:0] RELOAD_RST   = 8'h04;  // Baud reload after reset
  localparam logic [RELOAD_W-1:0] RELOAD_MIN   = 8'h02;  // Smallest reload: acknowledge clears synchroniser in time
  localparam logic [BYTE_W-1:0]   BUF_RST      = 8'h00;  // Transmit buffer after reset
  localparam logic [2:0]          SYNC_RST     = 3'h7;   // Idle bus reads high
  localparam logic [1:0]          HALF_RST     = 2'h0;   // Sub-phase counter reset

  // Start hold time: extra baud periods after a start before anything else
  localparam logic [1:0]          START_HALVES = 2'h1;

  // ----------------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ITX_IDLE,       // Bus released, nothing pending
    ITX_START,      // Driving start or restart sequence
    ITX_START_HOLD, // Required start time after SDA falls
    ITX_WAIT,       // Suspended: SCL low, waiting for buffer write
    ITX_LOW,        // SCL low, data set up
    ITX_HIGH,       // SCL released high
    ITX_STOP        // Driving stop sequence
  } itx_state_t;

endpackage

// ### design/itx_baud_if.sv
// Interface between the controller and its baud rate generator
`timescale 1ns/1ps
`default_nettype none
interface itx_baud_if;
  logic                               run;     // Generator counting
  logic                               load;    // Restart from reload value
  logic [itx_pkg::RELOAD_W-1:0]       reload;  // Programmed period
  logic                               roll;    // One-cycle rollover pulse

  modport ctrl (output run, output load, output reload, input roll);
  modport gen  (input run, input load, input reload, output roll);
endinterface
`default_nettype wire

// ### design/itx_baud_gen.sv
// Baud rate generator: counts system clocks down to a rollover
`timescale 1ns/1ps
`default_nettype none
module itx_baud_gen (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  nrst_i,
  // Controller side
  itx_baud_if.gen    baud
);

  // ----------------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------------
  logic [itx_pkg::RELOAD_W-1:0] cnt_reg;   // Cycles left in this half
  logic                         roll_reg;  // Registered rollover

  // Count down while running; reload at zero, so period is reload+1 clocks
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg  <= itx_pkg::RELOAD_RST;
      roll_reg <= 1'b0;
    end else if (baud.load || !baud.run) begin
      // Held at reload while suspended so the next half is full length
      cnt_reg  <= baud.reload;
      roll_reg <= 1'b0;
    end else if (cnt_reg == '0) begin
      cnt_reg  <= baud.reload;
      roll_reg <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg - 1'b1;
      roll_reg <= 1'b0;
    end
  end

  assign baud.roll = roll_reg;

  AST_ROLL_ONLY_RUN: assert property (@(posedge clk_i) disable iff (!nrst_i)
    roll_reg |-> $past(baud.run)) else $error("rollover while suspended");

endmodule
`default_nettype wire

// ### verification/itx_slave.sv
// Addressed slave model: counts bits, returns acknowledge
`timescale 1ns/1ps
`default_nettype none
module itx_slave (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Bus levels and bench control
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nack_i,
  output logic            sda_pull_o,
  output logic [7:0]      byte_o,
  output logic [3:0]      cnt_o
);
  logic       scl_reg;  // SCL one clock ago
  logic       sda_reg;  // SDA one clock ago
  logic [7:0] sh_reg;   // Bits gathered so far
  // ----------------------------------------------------------------------
  // Framing, shifting and acknowledge drive
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    scl_reg <= scl_i;
    sda_reg <= sda_i;
    if (!nrst_i) begin
      sda_pull_o <= 1'b0;
      cnt_o      <= 4'h0;
      byte_o     <= 8'h00;
      sh_reg     <= 8'h00;
    end else if (scl_i && scl_reg && sda_reg != sda_i) begin
      cnt_o      <= 4'h0;  // Start or stop restarts framing
      sda_pull_o <= 1'b0;
    end else if (scl_i && !scl_reg) begin
      cnt_o <= cnt_o + 4'h1;
      if (cnt_o < 4'h8) begin
        sh_reg <= {sh_reg[6:0], sda_i};  // MSB arrives first
      end
    end else if (!scl_i && scl_reg && cnt_o == 4'h8) begin
      sda_pull_o <= ~nack_i;  // Refuses only on bench command
      byte_o     <= sh_reg;
    end else if (!scl_i && scl_reg && cnt_o == 4'h9) begin
      sda_pull_o <= 1'b0;  // Let go after the ninth clock
      cnt_o      <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_itx_master_tx.sv
// Self-checking bench for the two-wire master transmit block
`timescale 1ns/1ps
`default_nettype none
module test_itx_master_tx;
  logic        clk_i = 1'b0, nrst_i = 1'b0;
  logic [7:0]  wdata = 8'h00, reload = 8'h04, rx_byte, b;
  logic        wr = 0, st = 0, rs = 0, sp = 0, ev_clr = 0, wc_clr = 0, nack = 0;
  logic        bf, ev, ack, write_collision_flag, busy, scl_oe, sda_oe, scl_o, sda_o, pull, ev_prev = 0;
  logic [3:0]  rx_cnt;
  logic        exp_q[$];                  // Expected acknowledge per event
  int          mismatches = 0, num_checks = 0, cycles = 0, hi_cnt = 0;
  logic [31:0] lfsr = 32'h00012de9;       // Fixed seed
  wire         scl_w = ~scl_oe;           // Pull-up unless pulled low
  wire         sda_w = ~(sda_oe | pull);
  itx_master_tx itx_master_tx_i (.clk_i(clk_i), .nrst_i(nrst_i), .buf_wdata_i(wdata), .buf_write_i(wr),
    .start_req_i(st), .restart_req_i(rs), .stop_req_i(sp), .event_clr_i(ev_clr), .write_collision_flag_clr_i(wc_clr),
    .baud_reload_i(reload), .buffer_full_flag_o(bf), .serial_event_flag_o(ev),
    .acknowledge_status_bit_o(ack), .write_collision_flag_o(write_collision_flag), .busy_o(busy), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe));
  itx_slave itx_slave_i (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
    .sda_pull_o(pull), .byte_o(rx_byte), .cnt_o(rx_cnt));
  initial forever #2.5 clk_i = ~clk_i;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (e !== g) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One-cycle request, launched and dropped on falling edges
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  // Note the expected result, wait for the event, then clear it
  task automatic wait_ev(input logic a);
    int n;
    exp_q.push_back(a);
    n = 0;
    while (ev !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    chk(8'h01, {7'h0, ev});
    pulse(ev_clr);
  endtask
  // One byte, optionally with a colliding second write mid-shift
  task automatic send(input logic [7:0] d, input logic a, input logic coll);
    wdata = d;
    pulse(wr);
    chk(8'h01, {7'h0, bf});
    if (coll) begin
      repeat (20) @(negedge clk_i);
      wdata = ~d;
      pulse(wr);
      chk(8'h01, {7'h0, write_collision_flag});
      pulse(wc_clr);
      chk(8'h00, {7'h0, write_collision_flag});
    end
    wait_ev(a);
    chk(d, rx_byte);
  endtask
  // ----------------------------------------------------------------------
  // Watcher: every fresh event takes the oldest note
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      stop_test();
    end
    if (ev === 1'b1 && ev_prev !== 1'b1 && exp_q.size() > 0) begin
      chk({7'h0, exp_q.pop_front()}, {7'h0, ack});
      chk(8'h00, {7'h0, bf});
    end
    ev_prev = ev;
  end
  // SCL high time inside a byte must be one baud period
  always @(posedge clk_i) begin
    if (scl_w) hi_cnt++;
    else begin
      if (hi_cnt != 0 && rx_cnt != 4'h0)
        chk(((reload < itx_pkg::RELOAD_MIN) ? itx_pkg::RELOAD_MIN : reload) + 8'h01, 8'(hi_cnt));
      hi_cnt = 0;
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk_i);
    nrst_i = 1'b1;
    chk(8'h00, {bf, ev, write_collision_flag, busy, scl_o, sda_o, scl_oe, sda_oe});
    pulse(st);
    wait_ev(1'b0);
    chk(8'h04, {5'h0, busy, scl_w, sda_w});
    b = rnd();
    send({b[7:1], 1'b0}, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      reload = 8'(i);
      nack = (i == 3);
      send(rnd(), i == 3, i == 1);
    end
    nack = 1'b0;
    pulse(rs);
    wait_ev(1'b1);
    send({b[7:1], 1'b1}, 1'b0, 1'b0);
    pulse(sp);
    wait_ev(1'b0);
    chk(8'h03, {5'h0, busy, scl_w, sda_w});
    repeat (4) @(negedge clk_i);
    chk(8'h00, 8'(exp_q.size()));
    stop_test();
  end
endmodule
`default_nettype wire
